// [src/clfr_consts.svh]
`ifndef CLFR_CONSTS_SVH
`define CLFR_CONSTS_SVH

// Register offsets
`define CLFR_ADDR_LIMIT_FLAGS  8'h2d
`define CLFR_ADDR_LIMIT_CFG    8'h2e
`define CLFR_ADDR_FREQ_STATUS  8'h2f
`define CLFR_ADDR_FREQ_CFG     8'h30

// Field layout of the code registers
`define CLFR_CODE_MSB          4
`define CLFR_CODE_LSB          0
`define CLFR_RSVD_ZERO         3'h0

// Reset values
`define CLFR_FREQ_STATUS_RST   5'h00
`define CLFR_LIMIT_CFG_RST     5'h00
`define CLFR_FREQ_CFG_RST      5'h00
`define CLFR_LIMIT_RES_RST     5'h00
`define CLFR_FLAGS_RST         8'h00

// Threshold scale in millivolts
`define CLFR_LIMIT_BASE_MV     11'h0c8
`define CLFR_LIMIT_STEP_MV     11'h032

// Phase count range
`define CLFR_MAX_PHASES        4'h8

`endif

// [src/clfr_pkg.sv]
package clfr_pkg;

  typedef logic [4:0]  clfr_code_t;
  typedef logic [7:0]  clfr_byte_t;
  typedef logic [12:0] clfr_khz_t;
  typedef logic [10:0] clfr_mv_t;

  typedef enum logic {
    CLFR_SAMPLE,
    CLFR_RUN
  } clfr_state_t;

endpackage : clfr_pkg

// [src/clfr_flag_bank.sv]
`timescale 1ns/10ps
`include "clfr_consts.svh"

module clfr_flag_bank
  import clfr_pkg::*;
#(
  parameter int N = 8
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  // Phase limit levels and read clear
  input  wire logic [N-1:0]  in_limit,
  input  wire logic          clr,
  // Sticky flags
  output logic      [N-1:0]  flags
);

  logic [N-1:0] prev;
  wire  [N-1:0] rise;
  wire  [N-1:0] next_flags;

  assign rise       = in_limit & ~prev;
  assign next_flags = (flags & ~{N{clr}}) | rise;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prev  <= '0;
      flags <= '0;
    end else begin
      prev  <= in_limit;
      flags <= next_flags;
    end
  end

endmodule : clfr_flag_bank

// [src/clfr_freq_lut.sv]
`timescale 1ns/10ps
`include "clfr_consts.svh"

module clfr_freq_lut
  import clfr_pkg::*;
(
  // Code and active phase count
  input  wire clfr_code_t  code,
  input  wire logic [3:0]  phases,
  // Switching frequency in kHz
  output clfr_khz_t        khz
);

  // One row per code, 8-phase column in the top bits, 1-phase in the low bits
  function automatic logic [103:0] clfr_row(input clfr_code_t c);
    logic [103:0] r;
    r = '0;
    case (c)
      5'h00: r = {13'd221, 13'd253, 13'd295, 13'd355, 13'd221, 13'd293, 13'd223, 13'd232};
      5'h01: r = {13'd244, 13'd276, 13'd330, 13'd399, 13'd244, 13'd329, 13'd243, 13'd252};
      5'h02: r = {13'd266, 13'd309, 13'd355, 13'd425, 13'd266, 13'd358, 13'd264, 13'd272};
      5'h03: r = {13'd293, 13'd327, 13'd387, 13'd460, 13'd293, 13'd381, 13'd294, 13'd297};
      5'h04: r = {13'd307, 13'd351, 13'd412, 13'd501, 13'd307, 13'd407, 13'd317, 13'd322};
      5'h05: r = {13'd333, 13'd384, 13'd441, 13'd542, 13'd333, 13'd450, 13'd335, 13'd340};
      5'h06: r = {13'd351, 13'd409, 13'd480, 13'd561, 13'd351, 13'd480, 13'd352, 13'd361};
      5'h07: r = {13'd373, 13'd431, 13'd499, 13'd615, 13'd373, 13'd510, 13'd380, 13'd385};
      5'h08: r = {13'd394, 13'd451, 13'd528, 13'd639, 13'd394, 13'd530, 13'd399, 13'd413};
      5'h09: r = {13'd421, 13'd481, 13'd559, 13'd676, 13'd421, 13'd562, 13'd420, 13'd435};
      5'h0a: r = {13'd449, 13'd495, 13'd593, 13'd725, 13'd449, 13'd600, 13'd436, 13'd456};
      5'h0b: r = {13'd469, 13'd525, 13'd612, 13'd746, 13'd469, 13'd614, 13'd454, 13'd478};
      5'h0c: r = {13'd479, 13'd563, 13'd639, 13'd757, 13'd479, 13'd631, 13'd483, 13'd500};
      5'h0d: r = {13'd509, 13'd570, 13'd681, 13'd799, 13'd509, 13'd663, 13'd508, 13'd509};
      5'h0e: r = {13'd518, 13'd588, 13'd697, 13'd831, 13'd518, 13'd688, 13'd526, 13'd518};
      5'h0f: r = {13'd543, 13'd617, 13'd722, 13'd874, 13'd543, 13'd722, 13'd543, 13'd540};
      5'h10: r = {13'd581, 13'd665, 13'd779, 13'd930, 13'd581, 13'd789, 13'd583, 13'd578};
      5'h11: r = {13'd649, 13'd718, 13'd881, 13'd1043, 13'd649, 13'd859, 13'd656, 13'd638};
      5'h12: r = {13'd708, 13'd790, 13'd937, 13'd1129, 13'd708, 13'd930, 13'd698, 13'd698};
      5'h13: r = {13'd751, 13'd868, 13'd1010, 13'd1211, 13'd751, 13'd1010, 13'd771, 13'd758};
      5'h14: r = {13'd799, 13'd918, 13'd1073, 13'd1278, 13'd799, 13'd1095, 13'd807, 13'd818};
      5'h15: r = {13'd866, 13'd1003, 13'd1136, 13'd1372, 13'd866, 13'd1147, 13'd860, 13'd878};
      5'h16: r = {13'd919, 13'd1025, 13'd1220, 13'd1449, 13'd919, 13'd1233, 13'd899, 13'd938};
      5'h17: r = {13'd964, 13'd1111, 13'd1297, 13'd1533, 13'd964, 13'd1260, 13'd950, 13'd972};
      5'h18: r = {13'd993, 13'd1140, 13'd1339, 13'd6716, 13'd993, 13'd1341, 13'd1003, 13'd1014};
      5'h19: r = {13'd1059, 13'd1198, 13'd1438, 13'd1687, 13'd1059, 13'd1372, 13'd1052,
                  13'd1067};
      5'h1a: r = {13'd1098, 13'd1262, 13'd1485, 13'd1734, 13'd1098, 13'd1450, 13'd1096,
                  13'd1106};
      5'h1b: r = {13'd1141, 13'd1295, 13'd1533, 13'd1821, 13'd1141, 13'd1539, 13'd1154,
                  13'd1155};
      5'h1c: r = {13'd1200, 13'd1338, 13'd1587, 13'd7530, 13'd1200, 13'd1619, 13'd1205,
                  13'd1201};
      5'h1d: r = {13'd1236, 13'd1405, 13'd1608, 13'd1954, 13'd1236, 13'd1618, 13'd1227,
                  13'd1245};
      5'h1e: r = {13'd1291, 13'd1459, 13'd1707, 13'd2012, 13'd1291, 13'd1674, 13'd1274,
                  13'd1280};
      default: r = {13'd1312, 13'd1493, 13'd1724, 13'd2096, 13'd1312, 13'd1724, 13'd1316,
                    13'd1330};
    endcase
    return r;
  endfunction : clfr_row

  wire [103:0] row;
  wire [2:0]   col;

  // Out-of-range phase counts fall back to the full 8-phase column
  assign col = (phases == 4'h0 || phases > `CLFR_MAX_PHASES) ? 3'h7 : 3'(phases - 4'h1);
  assign row = clfr_row(code);
  // code and phase count pick the frequency
  assign khz = row[col*13 +: 13];

endmodule : clfr_freq_lut

// [src/clfr_regs.sv]
`timescale 1ns/10ps
`include "clfr_consts.svh"

// Behaviour
// - Drive the test current into the limit resistor by default and capture its code continuously.
// - The host writes a 5-bit limit code to the limit configuration register for use as threshold.
// - Limit code bits 4:0 map linearly from 0.2 V at 0x00 in 50 mV steps to 1.75 V at 0x1F.
// - The register limit code replaces the resistor code only while its selection input is set.
// - A phase entering current limit sets its sticky flag in the limit flag register.
// - Flag bit 7 belongs to phase 8, down to bit 0 for phase 1.
// - At power-on the frequency pin code is sampled once, even codes only, default 00000.
// - The host-written frequency code applies only while the frequency selection input is set.
// - Both frequency registers hold a 5-bit code in bits 4:0; the config takes all 32 codes.
// - The active code and the active phase count give the switching frequency in kHz.
module clfr_regs
  import clfr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Register port from the serial host engine
  input  wire clfr_byte_t  reg_addr,
  input  wire clfr_byte_t  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output clfr_byte_t       reg_rdata,
  // Second-function selections
  input  wire logic        limit_reg_sel,
  input  wire logic        freq_reg_sel,
  // Limit resistor measurement
  output logic             limit_resistor_src_en,
  input  wire clfr_code_t  limit_resistor_code,
  input  wire logic        limit_resistor_valid,
  // Phase limit state
  input  wire logic [7:0]  phase_in_limit,
  input  wire logic [3:0]  active_phases,
  // Frequency select pin measurement
  input  wire clfr_code_t  freq_pin_code,
  input  wire logic        freq_pin_valid,
  // Applied settings
  output clfr_code_t       limit_thresh_code,
  output clfr_mv_t         limit_thresh_mv,
  output clfr_code_t       freq_code,
  output clfr_khz_t        freq_khz,
  output logic             freq_sampled
);

  clfr_state_t state;
  clfr_code_t  limit_cfg;
  clfr_code_t  limit_res_code;
  clfr_code_t  freq_status;
  clfr_code_t  freq_cfg;
  logic [7:0]  limit_flags;

  function automatic clfr_mv_t clfr_thresh_mv(input clfr_code_t c);
    return 11'(`CLFR_LIMIT_BASE_MV + 11'(c) * `CLFR_LIMIT_STEP_MV);
  endfunction : clfr_thresh_mv

  // reserved upper bits are always zero
  function automatic clfr_byte_t clfr_pad(input clfr_code_t c);
    return {`CLFR_RSVD_ZERO, c};
  endfunction : clfr_pad

  // Address decode
  wire sel_flags       = (reg_addr == `CLFR_ADDR_LIMIT_FLAGS);
  wire sel_limit_cfg   = (reg_addr == `CLFR_ADDR_LIMIT_CFG);
  wire sel_freq_status = (reg_addr == `CLFR_ADDR_FREQ_STATUS);
  wire sel_freq_cfg    = (reg_addr == `CLFR_ADDR_FREQ_CFG);

  wire wr_limit_cfg = reg_wr && sel_limit_cfg;
  wire wr_freq_cfg  = reg_wr && sel_freq_cfg;
  // Reading the flags clears them, so software sees each entry once
  wire rd_flags     = reg_rd && sel_flags;

  // unmapped addresses and reserved bits read zero
  wire clfr_byte_t next_rdata =
    sel_flags       ? limit_flags           :
    sel_limit_cfg   ? clfr_pad(limit_cfg)   :
    sel_freq_status ? clfr_pad(freq_status) :
    sel_freq_cfg    ? clfr_pad(freq_cfg)    : 8'h00;

  wire clfr_code_t next_limit_code = limit_reg_sel ? limit_cfg : limit_res_code;
  wire clfr_code_t next_freq_code  = freq_reg_sel ? freq_cfg : freq_status;

  // one sample at power-on, lowest bit forced even
  wire take_freq_pin = (state == CLFR_SAMPLE) && freq_pin_valid;
  wire clfr_code_t next_freq_status = {freq_pin_code[`CLFR_CODE_MSB:1], 1'b0};

  clfr_state_t next_state;
  always_comb begin
    case (state)
      CLFR_SAMPLE: next_state = freq_pin_valid ? CLFR_RUN : CLFR_SAMPLE;
      CLFR_RUN:    next_state = CLFR_RUN;
      default:     next_state = CLFR_SAMPLE;
    endcase
  end

  clfr_khz_t lut_khz;

  clfr_freq_lut u_freq_lut (
    .code   (next_freq_code),
    .phases (active_phases),
    .khz    (lut_khz)
  );

  // sticky flags, bit n is phase n+1
  clfr_flag_bank #(
    .N (8)
  ) u_flag_bank (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .in_limit (phase_in_limit),
    .clr      (rd_flags),
    .flags    (limit_flags)
  );

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state       <= CLFR_SAMPLE;
      freq_status <= `CLFR_FREQ_STATUS_RST;
    end else begin
      state <= next_state;
      if (take_freq_pin) begin
        freq_status <= next_freq_status;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      limit_cfg <= `CLFR_LIMIT_CFG_RST;
      freq_cfg  <= `CLFR_FREQ_CFG_RST;
    end else begin
      if (wr_limit_cfg) begin
        limit_cfg <= reg_wdata[`CLFR_CODE_MSB:`CLFR_CODE_LSB];
      end
      if (wr_freq_cfg) begin
        freq_cfg <= reg_wdata[`CLFR_CODE_MSB:`CLFR_CODE_LSB];
      end
    end
  end

  // source on by default, resistor code followed live
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      limit_resistor_src_en <= 1'b1;
      limit_res_code        <= `CLFR_LIMIT_RES_RST;
    end else begin
      limit_resistor_src_en <= 1'b1;
      if (limit_resistor_valid) begin
        limit_res_code <= limit_resistor_code;
      end
    end
  end

  // Applied settings and read data
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      limit_thresh_code <= `CLFR_LIMIT_RES_RST;
      limit_thresh_mv   <= `CLFR_LIMIT_BASE_MV;
      freq_code         <= `CLFR_FREQ_STATUS_RST;
      freq_khz          <= '0;
      freq_sampled      <= 1'b0;
      reg_rdata         <= 8'h00;
    end else begin
      limit_thresh_code <= next_limit_code;
      limit_thresh_mv   <= clfr_thresh_mv(next_limit_code);
      freq_code         <= next_freq_code;
      freq_khz          <= lut_khz;
      freq_sampled      <= (next_state == CLFR_RUN);
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // Helper for edge checks
  logic [7:0] phase_prev;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase_prev <= 8'h00;
    end else begin
      phase_prev <= phase_in_limit;
    end
  end
  wire [7:0] phase_rise = phase_in_limit & ~phase_prev;

  a_res_capture: assert property (
    limit_resistor_valid |=> limit_res_code == $past(limit_resistor_code))
    else $error("resistor limit code not captured");

  a_limit_write: assert property (
    (reg_wr && sel_limit_cfg && limit_reg_sel) ##1 (!reg_wr && limit_reg_sel)
      |=> limit_thresh_code == $past(reg_wdata[4:0], 2))
    else $error("written limit code not applied");

  a_limit_scale: assert property (
    limit_thresh_mv == 11'(11'd200 + 11'(limit_thresh_code) * 11'd50))
    else $error("limit threshold scale wrong");

  a_limit_source: assert property (
    !limit_reg_sel |=> limit_thresh_code == $past(limit_res_code))
    else $error("resistor limit code not used");

  a_flag_set: assert property (
    (phase_rise != 8'h00) |=> ((limit_flags & $past(phase_rise)) == $past(phase_rise)))
    else $error("limit flag missed on phase entry");

  a_flag_map: assert property (
    (phase_rise == 8'h80 && limit_flags == 8'h00) |=> limit_flags == 8'h80)
    else $error("phase 8 flag not in bit 7");

  a_status_once: assert property (
    state == CLFR_RUN |=> $stable(freq_status) && freq_status[0] == 1'b0)
    else $error("frequency status moved after sampling");

  a_freq_source: assert property (
    freq_reg_sel |=> freq_code == $past(freq_cfg))
    else $error("frequency config not applied");

  a_freq_cfg_odd: assert property (
    (reg_wr && sel_freq_cfg) |=> freq_cfg == $past(reg_wdata[4:0]))
    else $error("frequency config code not stored");

  a_freq_ends: assert property (
    (next_freq_code == 5'h1f && active_phases == 4'h8) |=> freq_khz == 13'd1312)
    else $error("8-phase top code frequency wrong");

  a_rsvd_zero: assert property (
    reg_rd |=> reg_rdata[7:5] == 3'h0 || $past(sel_flags))
    else $error("reserved bits read non-zero");

  a_res_hold: assert property (
    !limit_resistor_valid |=> $stable(limit_res_code))
    else $error("resistor limit code moved without valid");

  a_limit_cfg_store: assert property (
    (reg_wr && sel_limit_cfg) |=> limit_cfg == $past(reg_wdata[4:0]))
    else $error("limit config code not stored");

  a_limit_use_cfg: assert property (
    limit_reg_sel |=> limit_thresh_code == $past(limit_cfg))
    else $error("register limit code not used");

  a_flag_hold: assert property (
    !rd_flags |=> (limit_flags & $past(limit_flags)) == $past(limit_flags))
    else $error("limit flag lost without read");

  a_flag_clear: assert property (
    rd_flags |=> limit_flags == $past(phase_rise))
    else $error("limit flags wrong after read");

  a_freq_sample: assert property (
    (state == CLFR_SAMPLE && freq_pin_valid)
      |=> freq_status == {$past(freq_pin_code[4:1]), 1'b0} && freq_sampled)
    else $error("frequency pin code not sampled");

  a_freq_status_src: assert property (
    !freq_reg_sel |=> freq_code == $past(freq_status))
    else $error("frequency status code not used");

  a_freq_cfg_hold: assert property (
    !(reg_wr && sel_freq_cfg) |=> $stable(freq_cfg))
    else $error("frequency config moved without write");

  a_freq_base: assert property (
    (next_freq_code == 5'h00 && active_phases == 4'h8) |=> freq_khz == 13'd221)
    else $error("8-phase lowest code frequency wrong");

  a_unmapped_zero: assert property (
    (reg_rd && !sel_flags && !sel_limit_cfg && !sel_freq_status && !sel_freq_cfg)
      |=> reg_rdata == 8'h00)
    else $error("unmapped address read non-zero");

endmodule : clfr_regs

// [tb/clfr_host_model.sv]
`timescale 1ns/10ps

module clfr_host_model
  import clfr_pkg::*;
(
  // Clock
  input  wire logic  clk_sys,
  // Register port requests
  output clfr_byte_t reg_addr,
  output clfr_byte_t reg_wdata,
  output logic       reg_wr,
  output logic       reg_rd
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // host writes and reads codes
  // One strobe cycle, then one idle edge so no signal is assigned twice in a step
  task automatic access(input clfr_byte_t a, input clfr_byte_t d, input logic w);
    @(negedge clk_sys);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = w;
    reg_rd    = !w;
    @(negedge clk_sys);
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    // Released lines show the inverse, never the stale value
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : access
endmodule : clfr_host_model

// [tb/current_limit_and_freq_regs_test.sv]
`timescale 1ns/10ps
`include "clfr_consts.svh"

module current_limit_and_freq_regs_test
  import clfr_pkg::*;
();
  logic        clk_sys = 1'b0;
  logic        rst_b;
  clfr_byte_t  reg_addr;
  clfr_byte_t  reg_wdata;
  clfr_byte_t  reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        limit_reg_sel;
  logic        freq_reg_sel;
  logic        limit_resistor_src_en;
  clfr_code_t  limit_resistor_code;
  logic        limit_resistor_valid;
  logic [7:0]  phase_in_limit;
  logic [3:0]  active_phases;
  clfr_code_t  freq_pin_code;
  logic        freq_pin_valid;
  clfr_code_t  limit_thresh_code;
  clfr_mv_t    limit_thresh_mv;
  clfr_code_t  freq_code;
  clfr_khz_t   freq_khz;
  logic        freq_sampled;
  int          n_mismatch = 0;
  int          checked = 0;
  int          i;
  clfr_code_t  c;
  logic [31:0] seed = 32'h0d147db0;
  clfr_byte_t  exp_q [$];
  // Last entry: a phase count of zero falls back to the 8-phase column
  clfr_code_t  t_code [6] = '{5'h00, 5'h01, 5'h18, 5'h1f, 5'h13, 5'h05};
  logic [3:0]  t_ph   [6] = '{4'h8, 4'h8, 4'h5, 4'h1, 4'h3, 4'h0};
  logic [15:0] t_khz  [6] = '{16'h00dd, 16'h00f4, 16'h1a3c, 16'h0532, 16'h03f2, 16'h014d};

  always #25 clk_sys = ~clk_sys;

  clfr_host_model host (
    .clk_sys   (clk_sys),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd)
  );

  clfr_regs uut (
    .clk_sys               (clk_sys),
    .rst_b                 (rst_b),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata             (reg_rdata),
    .limit_reg_sel         (limit_reg_sel),
    .freq_reg_sel          (freq_reg_sel),
    .limit_resistor_src_en (limit_resistor_src_en),
    .limit_resistor_code   (limit_resistor_code),
    .limit_resistor_valid  (limit_resistor_valid),
    .phase_in_limit        (phase_in_limit),
    .active_phases         (active_phases),
    .freq_pin_code         (freq_pin_code),
    .freq_pin_valid        (freq_pin_valid),
    .limit_thresh_code     (limit_thresh_code),
    .limit_thresh_mv       (limit_thresh_mv),
    .freq_code             (freq_code),
    .freq_khz              (freq_khz),
    .freq_sampled          (freq_sampled)
  );

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x  = v ^ (v << 13);
    x  = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs

  task automatic chk_rd(input clfr_byte_t e);
    checked++;
    if (reg_rdata !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, e, reg_rdata);
    end
  endtask : chk_rd

  task automatic chk_out(input logic [15:0] got, input logic [15:0] e);
    checked++;
    if (got !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, e, got);
    end
  endtask : chk_out

  task automatic wr(input clfr_byte_t a, input clfr_byte_t d);
    host.access(a, d, 1'b1);
  endtask : wr

  task automatic rd_exp(input clfr_byte_t a, input clfr_byte_t e);
    exp_q.push_back(e);
    host.access(a, 8'h00, 1'b0);
  endtask : rd_exp

  task automatic wait3;
    repeat (3) @(negedge clk_sys);
  endtask : wait3

  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // Read data lands on the edge that takes the strobe; look once it has settled
  always @(posedge clk_sys) begin
    if (reg_rd === 1'b1) begin
      #5;
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("wrong value at %0t: expected none got %h", $time, reg_rdata);
      end else begin
        chk_rd(exp_q.pop_front());
      end
    end
  end

  initial begin
    #(50 * 4000);
    n_mismatch++;
    results();
  end

  initial begin
    rst_b = 1'b0;
    limit_reg_sel = 1'b0;
    freq_reg_sel = 1'b0;
    limit_resistor_code = 5'h00;
    limit_resistor_valid = 1'b0;
    phase_in_limit = 8'h00;
    active_phases = 4'h8;
    freq_pin_code = 5'h13;
    freq_pin_valid = 1'b0;
    repeat (6) @(negedge clk_sys);
    rst_b = 1'b1;
    freq_pin_valid = 1'b1;
    @(negedge clk_sys);
    freq_pin_code = 5'h0b;
    @(negedge clk_sys);
    freq_pin_valid = 1'b0;
    chk_out(16'(freq_sampled), 16'h0001);
    rd_exp(`CLFR_ADDR_FREQ_STATUS, 8'h12);
    rd_exp(`CLFR_ADDR_LIMIT_CFG, 8'h00);
    rd_exp(`CLFR_ADDR_FREQ_CFG, 8'h00);
    rd_exp(`CLFR_ADDR_LIMIT_FLAGS, 8'h00);
    chk_out(16'(freq_khz), 16'h02c4);
    chk_out(16'(limit_resistor_src_en), 16'h0001);
    // Resistor code tracked continuously, boundaries first
    limit_resistor_valid = 1'b1;
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      c = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : seed[4:0];
      limit_resistor_code = c;
      wait3();
      chk_out(16'(limit_thresh_code), 16'(c));
      chk_out(16'(limit_thresh_mv), 16'h00c8 + 16'h0032 * 16'(c));
    end
    wr(`CLFR_ADDR_LIMIT_CFG, 8'hff);
    rd_exp(`CLFR_ADDR_LIMIT_CFG, 8'h1f);
    chk_out(16'(limit_thresh_code), 16'(c));
    limit_reg_sel = 1'b1;
    wait3();
    chk_out(16'(limit_thresh_mv), 16'h06d6);
    wr(`CLFR_ADDR_LIMIT_CFG, 8'he1);
    wait3();
    chk_out(16'(limit_thresh_mv), 16'h00fa);
    limit_reg_sel = 1'b0;
    wait3();
    chk_out(16'(limit_thresh_code), 16'(c));
    wr(`CLFR_ADDR_FREQ_CFG, 8'hff);
    wait3();
    chk_out(16'(freq_code), 16'h0012);
    freq_reg_sel = 1'b1;
    wait3();
    chk_out(16'(freq_khz), 16'h0520);
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      wr(`CLFR_ADDR_FREQ_CFG, {seed[7:5], t_code[i]});
      rd_exp(`CLFR_ADDR_FREQ_CFG, {3'h0, t_code[i]});
      active_phases = t_ph[i];
      wait3();
      chk_out(16'(freq_khz), t_khz[i]);
    end
    freq_reg_sel = 1'b0;
    active_phases = 4'h8;
    wait3();
    chk_out(16'(freq_code), 16'h0012);
    wr(`CLFR_ADDR_FREQ_STATUS, 8'h04);
    rd_exp(`CLFR_ADDR_FREQ_STATUS, 8'h12);
    wr(8'h55, 8'h5a);
    rd_exp(8'h55, 8'h00);
    wr(`CLFR_ADDR_LIMIT_FLAGS, 8'hff);
    rd_exp(`CLFR_ADDR_LIMIT_FLAGS, 8'h00);
    // A level held high after the clear must not set the flag again
    for (i = 0; i < 8; i++) begin
      phase_in_limit = 8'h01 << i;
      @(negedge clk_sys);
      rd_exp(`CLFR_ADDR_LIMIT_FLAGS, 8'h01 << i);
      rd_exp(`CLFR_ADDR_LIMIT_FLAGS, 8'h00);
      phase_in_limit = 8'h00;
      @(negedge clk_sys);
    end
    // An entry in the very cycle of the clearing read must survive it
    fork
      rd_exp(`CLFR_ADDR_LIMIT_FLAGS, 8'h00);
      begin
        @(negedge clk_sys);
        phase_in_limit = 8'h80;
      end
    join
    rd_exp(`CLFR_ADDR_LIMIT_FLAGS, 8'h80);
    phase_in_limit = 8'h00;
    wait3();
    results();
  end
endmodule : current_limit_and_freq_regs_test
